/* File: design/ism_pkg.sv */
// Package for the interrupt source map: channel numbers, register map and flag carriers
package ism_pkg;

  // ==========================================================
  // Channel numbering
  localparam int ISM_NUM_CHAN = 28;
  localparam int ISM_CHAN_W = 5;
  localparam int ISM_CH_WDOG = 0;
  localparam int ISM_CH_SOFT = 1;
  localparam int ISM_CH_DBG_RX = 2;
  localparam int ISM_CH_DBG_TX = 3;
  localparam int ISM_CH_TMR0 = 4;
  localparam int ISM_CH_TMR1 = 5;
  localparam int ISM_CH_UART0 = 6;
  localparam int ISM_CH_UART1 = 7;
  localparam int ISM_CH_PWM = 8;
  localparam int ISM_CH_I2C = 9;
  localparam int ISM_CH_SPI0 = 10;
  localparam int ISM_CH_SPI1 = 11;
  localparam int ISM_CH_PLL = 12;
  localparam int ISM_CH_RTC = 13;
  localparam int ISM_CH_EXT0 = 14;
  localparam int ISM_CH_ADC = 18;
  localparam int ISM_CH_ACCF = 19;
  localparam int ISM_CH_CAN1 = 20;
  localparam int ISM_CH_CAN_HI = 24;
  localparam int ISM_NUM_EXT = 4;
  localparam int ISM_NUM_CAN = 4;
  localparam int ISM_NUM_CAN_LO = 2;

  // ==========================================================
  // Vectored slots
  localparam int ISM_NUM_SLOT = 16;
  localparam int ISM_SLOT_W = 4;
  localparam int ISM_SLOT_EN_BIT = 5;
  localparam int ISM_SLOT_DW = 6;

  // ==========================================================
  // Register map, byte addresses
  localparam int ISM_AW = 8;
  localparam logic [7:0] ISM_OFF_RAW_REQ = 8'h00;
  localparam logic [7:0] ISM_OFF_SOFT_REQ = 8'h04;
  localparam logic [7:0] ISM_OFF_CONFIG = 8'h08;
  localparam logic [7:0] ISM_OFF_FIQ_SEL = 8'h0c;
  localparam logic [7:0] ISM_OFF_EVT_STATUS = 8'h10;
  localparam logic [7:0] ISM_OFF_EVT_MASK = 8'h14;
  localparam logic [7:0] ISM_OFF_ACTIVE = 8'h18;
  localparam logic [7:0] ISM_OFF_SLOT_BASE = 8'h40;
  localparam logic [7:0] ISM_SLOT_SPAN_MASK = 8'hc0;
  localparam int ISM_SLOT_IDX_LSB = 2;
  localparam int ISM_CFG_FOUR_CAN_BIT = 0;
  localparam int ISM_ACT_VALID_BIT = 9;
  localparam logic [27:0] ISM_RST_MASK = 28'h0000000;
  localparam logic [31:0] ISM_RD_ZERO = 32'h00000000;

  // ==========================================================
  // Flag carriers, one group per peripheral
  typedef struct packed {
    logic [3:0] match_flag;
    logic [3:0] capture_flag;
  } ism_timer_flags_t;

  typedef struct packed {
    logic rx_line_status_flag;
    logic tx_holding_empty_flag;
    logic rx_data_avail_flag;
    logic char_timeout_flag;
    logic modem_status_flag;
  } ism_uart_flags_t;

  typedef struct packed {
    logic spi_transfer_done;
    logic spi_mode_fault;
  } ism_spi_flags_t;

  typedef struct packed {
    logic ssp_tx_raw_flag;
    logic ssp_rx_raw_flag;
    logic ssp_rx_timeout_raw;
    logic ssp_rx_overrun_raw;
  } ism_ssp_flags_t;

  typedef struct packed {
    logic tx_irq;
    logic rx_irq;
  } ism_can_flags_t;

  typedef struct packed {
    logic watchdog_irq_flag;
    logic debug_comm_receive;
    logic debug_comm_transmit;
    ism_timer_flags_t tmr0;
    ism_timer_flags_t tmr1;
    ism_uart_flags_t uart0;
    ism_uart_flags_t uart1;
    logic [6:0] pwm_match_flag;
    logic i2c_state_flag;
    ism_spi_flags_t spi0;
    ism_spi_flags_t spi1;
    ism_ssp_flags_t sync_serial_port;
    logic pll_locked_flag;
    logic clock_count_incr_flag;
    logic clock_alarm_flag;
    logic [3:0] ext_irq;
    logic adc_irq;
    logic [3:0] accept_filter_flag;
    ism_can_flags_t [3:0] can;
  } ism_flags_t;

endpackage : ism_pkg

/* File: design/ism_slot_mem.sv */
// Storage for the sixteen vectored slot entries with a registered read port
`timescale 1ns/1ps

module ism_slot_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [ism_pkg::ISM_SLOT_W-1:0] wr_idx,
  input wire logic [ism_pkg::ISM_SLOT_DW-1:0] wr_data,
  input wire logic [ism_pkg::ISM_SLOT_W-1:0] rd_idx,
  output logic [ism_pkg::ISM_SLOT_DW-1:0] rd_data,
  output logic [ism_pkg::ISM_NUM_SLOT*ism_pkg::ISM_SLOT_DW-1:0] slots_flat
);

  // ==========================================================
  // Slot array
  logic [ism_pkg::ISM_SLOT_DW-1:0] slot_reg [ism_pkg::ISM_NUM_SLOT];
  logic [ism_pkg::ISM_SLOT_DW-1:0] rd_data_reg;

  // Entries are flops, not RAM, because the priority logic scans all of them at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ism_pkg::ISM_NUM_SLOT; i++) begin
        slot_reg[i] <= '0;
      end
    end else if (wr_en) begin
      slot_reg[wr_idx] <= wr_data;
    end
  end

  // Read data leaves through a register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= slot_reg[rd_idx];
    end
  end

  assign rd_data = rd_data_reg;

  // Flattened view for the parallel priority scan
  genvar g;
  generate
    for (g = 0; g < ism_pkg::ISM_NUM_SLOT; g++) begin : g_flat
      assign slots_flat[g*ism_pkg::ISM_SLOT_DW +: ism_pkg::ISM_SLOT_DW] = slot_reg[g];
    end
  endgenerate

endmodule : ism_slot_mem

/* File: design/ism_source_map.sv */
// Interrupt source map: peripheral flags to controller channels, with classification
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps

module ism_source_map (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ism_pkg::ism_flags_t flags,
  output logic [ism_pkg::ISM_NUM_CHAN-1:0] chan_req,
  output logic fiq_req,
  output logic irq_req,
  output logic vect_valid,
  output logic [ism_pkg::ISM_SLOT_W-1:0] vect_slot,
  output logic evt_irq
);

  localparam int NC = ism_pkg::ISM_NUM_CHAN;
  localparam int NS = ism_pkg::ISM_NUM_SLOT;
  localparam int DW = ism_pkg::ISM_SLOT_DW;

  // ==========================================================
  // Helper functions
  function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] off);
    addr_hit = (a[ism_pkg::ISM_AW-1:0] == off) && (a[31:ism_pkg::ISM_AW] == '0);
  endfunction : addr_hit

  function automatic logic [NC-1:0] widen(input logic [31:0] d);
    widen = d[NC-1:0];
  endfunction : widen

  // ==========================================================
  // Registers
  logic soft_req_reg;
  logic four_can_reg;
  logic [NC-1:0] fiq_sel_reg;
  logic [NC-1:0] evt_status_reg;
  logic [NC-1:0] evt_status_next;
  logic [NC-1:0] evt_mask_reg;
  logic [NC-1:0] chan_req_reg;
  logic fiq_req_reg;
  logic irq_req_reg;
  logic vect_valid_reg;
  logic [ism_pkg::ISM_SLOT_W-1:0] vect_slot_reg;
  logic [ism_pkg::ISM_CHAN_W-1:0] vect_chan_reg;
  logic evt_irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // ==========================================================
  // Channel formation
  logic [NC-1:0] chan_raw;

  // Each channel but the soft request, UART0 and the upper CAN pairs is a plain OR of its source flags; the SPI1 channel also takes the sync serial port
  assign chan_raw[ism_pkg::ISM_CH_WDOG] = flags.watchdog_irq_flag;
  assign chan_raw[ism_pkg::ISM_CH_SOFT] = soft_req_reg;
  assign chan_raw[ism_pkg::ISM_CH_DBG_RX] = flags.debug_comm_receive;
  assign chan_raw[ism_pkg::ISM_CH_DBG_TX] = flags.debug_comm_transmit;
  assign chan_raw[ism_pkg::ISM_CH_TMR0] = |flags.tmr0;
  assign chan_raw[ism_pkg::ISM_CH_TMR1] = |flags.tmr1;
  // Port 0 has no modem lines, so its modem flag input is ignored
  assign chan_raw[ism_pkg::ISM_CH_UART0] = flags.uart0.rx_line_status_flag
      | flags.uart0.tx_holding_empty_flag | flags.uart0.rx_data_avail_flag
      | flags.uart0.char_timeout_flag;
  assign chan_raw[ism_pkg::ISM_CH_UART1] = |flags.uart1;
  assign chan_raw[ism_pkg::ISM_CH_PWM] = |flags.pwm_match_flag;
  assign chan_raw[ism_pkg::ISM_CH_I2C] = flags.i2c_state_flag;
  assign chan_raw[ism_pkg::ISM_CH_SPI0] = |flags.spi0;
  assign chan_raw[ism_pkg::ISM_CH_SPI1] = (|flags.spi1) | (|flags.sync_serial_port);
  assign chan_raw[ism_pkg::ISM_CH_PLL] = flags.pll_locked_flag;
  assign chan_raw[ism_pkg::ISM_CH_RTC] = flags.clock_count_incr_flag
      | flags.clock_alarm_flag;
  assign chan_raw[ism_pkg::ISM_CH_ADC] = flags.adc_irq;
  assign chan_raw[ism_pkg::ISM_CH_ACCF] = |flags.accept_filter_flag;

  // External inputs and CAN pairs; the upper two controllers exist only when enabled
  genvar g;
  generate
    for (g = 0; g < ism_pkg::ISM_NUM_EXT; g++) begin : g_ext
      assign chan_raw[ism_pkg::ISM_CH_EXT0 + g] = flags.ext_irq[g];
    end
    for (g = 0; g < ism_pkg::ISM_NUM_CAN; g++) begin : g_can
      if (g < ism_pkg::ISM_NUM_CAN_LO) begin : g_lo
        assign chan_raw[ism_pkg::ISM_CH_CAN1 + 2*g] = flags.can[g].tx_irq;
        assign chan_raw[ism_pkg::ISM_CH_CAN1 + 2*g + 1] = flags.can[g].rx_irq;
      end else begin : g_hi
        assign chan_raw[ism_pkg::ISM_CH_CAN1 + 2*g] = four_can_reg
            & flags.can[g].tx_irq;
        assign chan_raw[ism_pkg::ISM_CH_CAN1 + 2*g + 1] = four_can_reg
            & flags.can[g].rx_irq;
      end
    end
  endgenerate

  // ==========================================================
  // Classification
  logic [NS*DW-1:0] slots_flat;
  logic [DW-1:0] slot_rd_data;
  logic [NC-1:0] fiq_lines;
  logic [NC-1:0] irq_lines;
  logic hit_any;
  logic [ism_pkg::ISM_SLOT_W-1:0] hit_slot;
  logic [ism_pkg::ISM_CHAN_W-1:0] hit_chan;

  // Fast lines are those marked in the select mask; the rest go to the normal request
  assign fiq_lines = chan_req_reg & fiq_sel_reg;
  assign irq_lines = chan_req_reg & ~fiq_sel_reg;

  // Scan from the highest slot down, so the lowest-numbered requesting slot wins when several are requesting
  always_comb begin
    logic [DW-1:0] ent;
    ent = '0;
    hit_any = 1'b0;
    hit_slot = '0;
    hit_chan = '0;
    for (int i = NS - 1; i >= 0; i--) begin
      ent = slots_flat[i*DW +: DW];
      // Channel codes past the last channel never match
      if (ent[ism_pkg::ISM_SLOT_EN_BIT] && (ent[ism_pkg::ISM_CHAN_W-1:0] < NC)
          && irq_lines[ent[ism_pkg::ISM_CHAN_W-1:0]]) begin
        hit_any = 1'b1;
        hit_slot = ism_pkg::ISM_SLOT_W'(i);
        hit_chan = ent[ism_pkg::ISM_CHAN_W-1:0];
      end
    end
  end

  // ==========================================================
  // Bus decode
  logic setup_ph;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic hit_raw;
  logic hit_soft;
  logic hit_cfg;
  logic hit_fiq;
  logic hit_stat;
  logic hit_mask;
  logic hit_act;
  logic hit_slot_reg;
  logic mapped;
  logic [31:0] rd_mux;

  // One wait state: pready rises on the first access edge, the transfer ends on the next
  assign setup_ph = psel & ~penable;
  assign acc_done = psel & penable & pready_reg;
  assign wr_done = acc_done & pwrite & ~pslverr_reg;
  assign rd_done = acc_done & ~pwrite & ~pslverr_reg;
  assign hit_raw = addr_hit(paddr, ism_pkg::ISM_OFF_RAW_REQ);
  assign hit_soft = addr_hit(paddr, ism_pkg::ISM_OFF_SOFT_REQ);
  assign hit_cfg = addr_hit(paddr, ism_pkg::ISM_OFF_CONFIG);
  assign hit_fiq = addr_hit(paddr, ism_pkg::ISM_OFF_FIQ_SEL);
  assign hit_stat = addr_hit(paddr, ism_pkg::ISM_OFF_EVT_STATUS);
  assign hit_mask = addr_hit(paddr, ism_pkg::ISM_OFF_EVT_MASK);
  assign hit_act = addr_hit(paddr, ism_pkg::ISM_OFF_ACTIVE);
  assign hit_slot_reg = ((paddr[ism_pkg::ISM_AW-1:0] & ism_pkg::ISM_SLOT_SPAN_MASK)
      == ism_pkg::ISM_OFF_SLOT_BASE) && (paddr[31:ism_pkg::ISM_AW] == '0)
      && (paddr[1:0] == 2'h0);
  assign mapped = hit_raw | hit_soft | hit_cfg | hit_fiq | hit_stat | hit_mask
      | hit_act | hit_slot_reg;

  // Read selection; slot data comes from the memory's registered port
  always_comb begin
    rd_mux = ism_pkg::ISM_RD_ZERO;
    if (hit_raw) begin
      rd_mux[NC-1:0] = chan_req_reg;
    end else if (hit_soft) begin
      rd_mux[ism_pkg::ISM_CH_SOFT] = soft_req_reg;
    end else if (hit_cfg) begin
      rd_mux[ism_pkg::ISM_CFG_FOUR_CAN_BIT] = four_can_reg;
    end else if (hit_fiq) begin
      rd_mux[NC-1:0] = fiq_sel_reg;
    end else if (hit_stat) begin
      rd_mux[NC-1:0] = evt_status_reg;
    end else if (hit_mask) begin
      rd_mux[NC-1:0] = evt_mask_reg;
    end else if (hit_act) begin
      rd_mux[ism_pkg::ISM_ACT_VALID_BIT] = vect_valid_reg;
      rd_mux[ism_pkg::ISM_CHAN_W +: ism_pkg::ISM_SLOT_W] = vect_slot_reg;
      rd_mux[ism_pkg::ISM_CHAN_W-1:0] = vect_chan_reg;
    end else if (hit_slot_reg) begin
      rd_mux[DW-1:0] = slot_rd_data;
    end
  end

  ism_slot_mem u_slots (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_done & hit_slot_reg),
    .wr_idx(paddr[ism_pkg::ISM_SLOT_IDX_LSB +: ism_pkg::ISM_SLOT_W]),
    .wr_data(pwdata[DW-1:0]),
    .rd_idx(paddr[ism_pkg::ISM_SLOT_IDX_LSB +: ism_pkg::ISM_SLOT_W]),
    .rd_data(slot_rd_data),
    .slots_flat(slots_flat)
  );

  // ==========================================================
  // Bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= ism_pkg::ISM_RD_ZERO;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      if (setup_ph) begin
        pslverr_reg <= ~mapped;
      end
      if (psel & penable & ~pready_reg) begin
        prdata_reg <= pwrite ? ism_pkg::ISM_RD_ZERO : rd_mux;
      end
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_req_reg <= 1'b0;
      four_can_reg <= 1'b0;
      fiq_sel_reg <= '0;
      evt_mask_reg <= ism_pkg::ISM_RST_MASK;
    end else if (wr_done) begin
      if (hit_soft) soft_req_reg <= pwdata[ism_pkg::ISM_CH_SOFT];
      if (hit_cfg) four_can_reg <= pwdata[ism_pkg::ISM_CFG_FOUR_CAN_BIT];
      if (hit_fiq) fiq_sel_reg <= widen(pwdata);
      if (hit_mask) evt_mask_reg <= widen(pwdata);
    end
  end

  // ==========================================================
  // Event status: a rising channel sets its bit; a new event beats a read clear
  // A read clears only the bits it returned, so an event after the capture survives
  assign evt_status_next = (evt_status_reg
      & ~((rd_done & hit_stat) ? prdata_reg[NC-1:0] : '0)) | (chan_raw & ~chan_req_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status_reg <= '0;
      evt_irq_reg <= 1'b0;
    end else begin
      evt_status_reg <= evt_status_next;
      evt_irq_reg <= |(evt_status_next & evt_mask_reg);
    end
  end

  // ==========================================================
  // Request outputs: channels one flop stage after the flags, class and vector outputs two
  // The extra cycle keeps every output glitch free at the cost of one clock latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_req_reg <= '0;
      fiq_req_reg <= 1'b0;
      irq_req_reg <= 1'b0;
      vect_valid_reg <= 1'b0;
      vect_slot_reg <= '0;
      vect_chan_reg <= '0;
    end else begin
      chan_req_reg <= chan_raw;
      fiq_req_reg <= |fiq_lines;
      irq_req_reg <= |irq_lines;
      vect_valid_reg <= hit_any;
      vect_slot_reg <= hit_slot;
      vect_chan_reg <= hit_chan;
    end
  end

  assign chan_req = chan_req_reg;
  assign fiq_req = fiq_req_reg;
  assign irq_req = irq_req_reg;
  assign vect_valid = vect_valid_reg;
  assign vect_slot = vect_slot_reg;
  assign evt_irq = evt_irq_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule : ism_source_map

/* File: sim/ism_ctrl_model.sv */
// Behavioural model of the controller request inputs that face the source map
`timescale 1ns/1ps

module ism_ctrl_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ism_pkg::ISM_NUM_CHAN-1:0] chan_req,
  output logic [ism_pkg::ISM_NUM_CHAN-1:0] seen_reg
);
  // ==========================================================
  // Request capture
  // Levels are sampled each edge; once high a channel stays marked, so a
  // single stray cycle on an unused channel is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= '0;
    end else begin
      seen_reg <= seen_reg | chan_req;
    end
  end
endmodule : ism_ctrl_model

/* File: sim/ism_source_map_properties.sv */
// Concurrent checks on the flag to channel mapping of the source map
`timescale 1ns/1ps

module ism_source_map_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire ism_pkg::ism_flags_t flags,
  input wire logic [ism_pkg::ISM_NUM_CHAN-1:0] chan_req,
  input wire logic fiq_req,
  input wire logic irq_req,
  input wire logic vect_valid
);
  // ==========================================================
  // Timing frame: one register stage from flags to channels
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wdog_chan: assert property (flags.watchdog_irq_flag |=> chan_req[0])
    else $error("watchdog flag not on channel 0");
  a_debug_chans: assert property (chan_req[3:2] == $past({flags.debug_comm_transmit,
    flags.debug_comm_receive})) else $error("debug channels wrong");
  a_timer_chans: assert property (chan_req[5:4] == {|$past(flags.tmr1),
    |$past(flags.tmr0)}) else $error("timer channels wrong");
  a_uart_chans: assert property (chan_req[7:6] == {|$past(flags.uart1),
    |$past(flags.uart0[4:1])}) else $error("serial port channels wrong");
  a_misc_chans: assert property (chan_req[13:8] == $past({flags.clock_count_incr_flag
    | flags.clock_alarm_flag, flags.pll_locked_flag, (|flags.spi1)
    | (|flags.sync_serial_port), |flags.spi0, flags.i2c_state_flag,
    |flags.pwm_match_flag})) else $error("channels 8 to 13 wrong");
  a_ext_chans: assert property (chan_req[17:14] == $past(flags.ext_irq))
    else $error("external channels wrong");
  a_adc_filter: assert property (chan_req[19:18] == {|$past(flags.accept_filter_flag),
    $past(flags.adc_irq)}) else $error("converter or filter channel wrong");
  a_can_low: assert property (chan_req[23:20] == $past({flags.can[1].rx_irq,
    flags.can[1].tx_irq, flags.can[0].rx_irq, flags.can[0].tx_irq}))
    else $error("first two CAN channel pairs wrong");
  a_can_high: assert property ((chan_req[27:24] & ~$past({flags.can[3].rx_irq,
    flags.can[3].tx_irq, flags.can[2].rx_irq, flags.can[2].tx_irq})) == 4'h0)
    else $error("upper CAN channels without source");
  a_level_fall: assert property ((flags == '0) |=> (chan_req[27:2] == '0 && !chan_req[0]))
    else $error("channel held with no flag set");
  a_vect_irq: assert property (vect_valid |-> irq_req)
    else $error("vector valid without normal request");
  a_class_src: assert property ((fiq_req || irq_req) |-> $past(chan_req) != '0)
    else $error("class output without channel request");
endmodule : ism_source_map_properties

bind ism_source_map ism_source_map_properties u_ism_source_map_properties (
  .pclk(pclk),
  .presetn(presetn),
  .flags(flags),
  .chan_req(chan_req),
  .fiq_req(fiq_req),
  .irq_req(irq_req),
  .vect_valid(vect_valid)
);

/* File: sim/ism_source_map_tb.sv */
// Self-checking bench for the interrupt source map
`timescale 1ns/1ps

module ism_source_map_tb;
  localparam int FW = $bits(ism_pkg::ism_flags_t);
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h00000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ism_pkg::ism_flags_t flags = '0;
  ism_pkg::ism_flags_t f;
  logic [27:0] chan_req;
  logic [27:0] seen_reg;
  logic fiq_req;
  logic irq_req;
  logic vect_valid;
  logic [3:0] vect_slot;
  logic evt_irq;
  logic [31:0] rd;
  logic er;
  int e;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  ism_source_map u_ism_source_map (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flags(flags), .chan_req(chan_req),
    .fiq_req(fiq_req), .irq_req(irq_req), .vect_valid(vect_valid), .vect_slot(vect_slot),
    .evt_irq(evt_irq));
  ism_ctrl_model u_ism_ctrl_model (.pclk(pclk), .presetn(presetn), .chan_req(chan_req),
    .seen_reg(seen_reg));

  // ==========================================================
  // Clock and hang guard
  always #12.5 pclk = ~pclk;
  // A stuck handshake would otherwise spin forever
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_of_test();
    end
  end

  // ==========================================================
  // Helpers
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Pready is read right at the edge, before that edge's updates land
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(what, exp, rd);
    chk("slverr", 32'h0, {31'h0, er});
  endtask : rdchk

  // Channel expected for a single flag bit; -1 where nothing may rise
  function automatic int exp_chan(input int b, input logic cfg);
    if (b == 64) return 0;
    if (b == 63) return 2;
    if (b == 62) return 3;
    if (b >= 54) return 4;
    if (b >= 46) return 5;
    if (b >= 42) return 6;
    if (b == 41) return -1;
    if (b >= 36) return 7;
    if (b >= 29) return 8;
    if (b == 28) return 9;
    if (b >= 26) return 10;
    if (b >= 20) return 11;
    if (b == 19) return 12;
    if (b >= 17) return 13;
    if (b >= 13) return 14 + (b - 13);
    if (b == 12) return 18;
    if (b >= 8) return 19;
    if (b >= 4 && !cfg) return -1;
    return 20 + 2 * (b / 2) + ((b % 2 == 1) ? 0 : 1);
  endfunction : exp_chan

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset_outs", 32'h0, {fiq_req, irq_req, vect_valid, evt_irq, chan_req});
    rdchk("evt_mask_rst", ism_pkg::ISM_OFF_EVT_MASK, 32'h0);
    rdchk("config_rst", ism_pkg::ISM_OFF_CONFIG, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], er});
    apb(1'b1, ism_pkg::ISM_OFF_RAW_REQ, 32'h0fffffff);
    rdchk("raw_ro", ism_pkg::ISM_OFF_RAW_REQ, 32'h0);
    // Walk one flag at a time, both CAN variants
    for (int cfg = 0; cfg < 2; cfg++) begin
      apb(1'b1, ism_pkg::ISM_OFF_CONFIG, 32'(cfg));
      for (int b = 0; b < FW; b++) begin
        e = exp_chan(b, cfg[0]);
        flags <= ism_pkg::ism_flags_t'({{(FW-1){1'b0}}, 1'b1} << b);
        repeat (3) @(posedge pclk);
        chk("chan_set", (e < 0) ? 32'h0 : (32'h1 << e), {4'h0, chan_req});
        flags <= '0;
        repeat (3) @(posedge pclk);
        chk("chan_clear", 32'h0, {4'h0, chan_req});
      end
    end
    chk("ctrl_seen", 32'h0ffffffd, {4'h0, seen_reg});
    apb(1'b1, ism_pkg::ISM_OFF_SOFT_REQ, 32'h2);
    repeat (3) @(posedge pclk);
    chk("soft_chan", 32'h2, {4'h0, chan_req});
    apb(1'b1, ism_pkg::ISM_OFF_SOFT_REQ, 32'h0);
    // Classification, slot priority and event interrupt
    apb(1'b0, ism_pkg::ISM_OFF_EVT_STATUS, 32'h0);
    apb(1'b1, ism_pkg::ISM_OFF_EVT_MASK, 32'h00004000);
    apb(1'b1, ism_pkg::ISM_OFF_FIQ_SEL, 32'h1);
    apb(1'b1, ism_pkg::ISM_OFF_SLOT_BASE, 32'h2e);
    apb(1'b1, ism_pkg::ISM_OFF_SLOT_BASE + 8'h04, 32'h2f);
    f = '0;
    f.watchdog_irq_flag = 1'b1;
    f.ext_irq = 4'h3;
    flags <= f;
    repeat (4) @(posedge pclk);
    chk("class_outs", 32'he1, {24'h0, fiq_req, irq_req, vect_valid, vect_slot, evt_irq});
    rdchk("evt_status", ism_pkg::ISM_OFF_EVT_STATUS, 32'h0000c001);
    repeat (2) @(posedge pclk);
    chk("evt_cleared", 32'h0, {31'h0, evt_irq});
    f.ext_irq = 4'h6;
    flags <= f;
    repeat (4) @(posedge pclk);
    chk("slot_next", 32'h22, {26'h0, vect_valid, vect_slot, evt_irq});
    rdchk("active", ism_pkg::ISM_OFF_ACTIVE, 32'h0000022f);
    rdchk("slot_rd", ism_pkg::ISM_OFF_SLOT_BASE + 8'h04, 32'h0000002f);
    rdchk("fiq_sel_rd", ism_pkg::ISM_OFF_FIQ_SEL, 32'h00000001);
    rdchk("evt_masked", ism_pkg::ISM_OFF_EVT_STATUS, 32'h00010000);
    f.ext_irq = 4'h0;
    flags <= f;
    repeat (4) @(posedge pclk);
    chk("fast_only", 32'h4, {29'h0, fiq_req, irq_req, vect_valid});
    flags <= '0;
    end_of_test();
  end
endmodule : ism_source_map_tb
